// *** hdl/zol_loop_ctrl.v ***
// Zero-overhead loop controller for the instruction fetch path
//
// What this block does
// (RULE1) Setup loads counter with source minus one
// (RULE2) Zero source wraps, loops two-to-32 times
// (RULE3) End is setup address plus four plus offset
// (RULE4) Begin is setup address plus three
// (RULE5) Sequential hit on end, nonzero count: redirect
// (RULE6) Redirect in fetch, no branch penalty
// (RULE7) Branch or jump to end never loops
// (RULE8) Software avoids call as last instruction
// (RULE9) One register set; new setup overwrites
// (RULE10) Software aligns first loop-body instruction
// (RULE11) Exception mode suppresses loop-back; a redirect already held pending for the extra cycle still issues
// (RULE12) First loop-back may cost one cycle
// (RULE13) Sync or end write slows next loop-back
// (RULE14) Compare every sequential next-fetch address
//
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
`include "zol_map.vh"
module zol_loop_ctrl #(
  parameter AW = 32
) (
  // Clock and reset
  input wire core_clk_in,
  input wire reset_in,
  // Loop setup from execute
  input wire setup_valid_in,
  input wire [AW-1:0] setup_pc_in,
  input wire [AW-1:0] setup_src_in,
  input wire [7:0] loop_offset_field_in,
  // Processor state and sync
  input wire exception_mode_flag_in,
  input wire instruction_sync_op_in,
  // Fetch side
  input wire fetch_valid_in,
  input wire fetch_seq_in,
  input wire fetch_len3_in,
  input wire [AW-1:0] fetch_pc_in,
  // Register port
  input wire [3:0] reg_addr_in,
  input wire [31:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output reg [31:0] reg_rdata_out,
  // Fetch redirect
  output reg redirect_out,
  output reg [AW-1:0] redirect_pc_out,
  output reg fetch_stall_out,
  // Visible loop state
  output reg [AW-1:0] iteration_counter_out,
  output reg [AW-1:0] loop_begin_address_out,
  output reg [AW-1:0] loop_end_address_out
);
  // Architectural loop registers, single set only
  reg [AW-1:0] iteration_counter_reg;
  reg [AW-1:0] iteration_counter_next;
  reg [AW-1:0] loop_begin_address_reg;
  reg [AW-1:0] loop_begin_address_next;
  reg [AW-1:0] loop_end_address_reg;
  reg [AW-1:0] loop_end_address_next;
  // Slow-path flag: next loop-back takes an extra cycle
  reg slow_reg;
  reg slow_next;
  // Redirect held pending during the extra cycle
  reg pend_reg;
  reg pend_next;
  // Count of loop-backs taken, for software
  reg [31:0] loopbacks_reg;
  reg [31:0] loopbacks_next;
  // Read data staging
  reg [31:0] rdata_next;
  // Redirect outputs next values
  reg redirect_next;
  reg [AW-1:0] redirect_pc_next;
  reg stall_next;
  // Comparator results
  wire [AW-1:0] seq_pc;
  wire end_hit;
  wire take_back;

  // Sequential next-fetch compare against loop end
  zol_addr_cmp #(
    .AW(AW)
  ) u_cmp (
    .fetch_pc_in(fetch_pc_in),
    .fetch_len3_in(fetch_len3_in),
    .loop_end_in(loop_end_address_reg),
    .seq_pc_out(seq_pc),
    .hit_out(end_hit)
  );

  // Cut a value to the 32-bit bus width
  function [31:0] to_word;
    input [AW-1:0] v;
    begin
      to_word = v[31:0];
    end
  endfunction

  // (RULE7) Only sequential fetches loop
  // (RULE11) Suppressed in exception mode
  // (RULE14) Both fetch lengths, 2 and 3 bytes, compared
  assign take_back = fetch_valid_in & fetch_seq_in & end_hit &
    (iteration_counter_reg != {AW{1'b0}}) & ~exception_mode_flag_in & ~pend_reg;

  // Next-state logic for loop registers and redirect
  always @* begin
    iteration_counter_next = iteration_counter_reg;
    loop_begin_address_next = loop_begin_address_reg;
    loop_end_address_next = loop_end_address_reg;
    slow_next = slow_reg;
    pend_next = 1'b0;
    loopbacks_next = loopbacks_reg;
    redirect_next = 1'b0;
    redirect_pc_next = redirect_pc_out;
    stall_next = 1'b0;
    // (RULE13) Sync op slows next loop-back
    if (instruction_sync_op_in) begin
      slow_next = 1'b1;
    end
    // Held redirect issues after the extra cycle
    if (pend_reg) begin
      redirect_next = 1'b1;
      redirect_pc_next = loop_begin_address_reg;
      iteration_counter_next = iteration_counter_reg - {{(AW-1){1'b0}}, 1'b1};
      loopbacks_next = loopbacks_reg + 32'h1;
    end else if (take_back) begin
      // (RULE12) Slowed loop-back waits one cycle
      if (slow_reg) begin
        pend_next = 1'b1;
        stall_next = 1'b1;
        slow_next = 1'b0;
      end else begin
        // (RULE5) Redirect to begin, decrement count
        // (RULE6) Redirect registered, reaches fetch the cycle after the hit
        redirect_next = 1'b1;
        redirect_pc_next = loop_begin_address_reg;
        iteration_counter_next = iteration_counter_reg - {{(AW-1){1'b0}}, 1'b1};
        loopbacks_next = loopbacks_reg + 32'h1;
      end
    end
    // Software writes to loop registers
    if (reg_wr_in) begin
      case (reg_addr_in)
        `ZOL_OFF_COUNT: begin
          iteration_counter_next = reg_wdata_in[AW-1:0];
        end
        `ZOL_OFF_BEGIN: begin
          loop_begin_address_next = reg_wdata_in[AW-1:0];
        end
        `ZOL_OFF_END: begin
          // (RULE13) End write slows next loop-back
          loop_end_address_next = reg_wdata_in[AW-1:0];
          slow_next = 1'b1;
        end
        `ZOL_OFF_LOOPBACKS: begin
          loopbacks_next = reg_wdata_in;
        end
        default: begin
          slow_next = slow_next;
        end
      endcase
    end
    // Setup wins over everything but the loop-back count; one set of registers
    if (setup_valid_in) begin
      // (RULE1) Counter is source minus one
      // (RULE2) Zero wraps to all ones
      iteration_counter_next = setup_src_in - {{(AW-1){1'b0}}, 1'b1};
      // (RULE4) Begin after setup instruction
      loop_begin_address_next = setup_pc_in + `ZOL_BEGIN_INC;
      // (RULE3) End with zero-extended offset
      loop_end_address_next = setup_pc_in + `ZOL_END_INC +
        {{(AW-8){1'b0}}, loop_offset_field_in};
      // (RULE9) Overwrite; new loop is a first loop-back
      // (RULE12) First loop-back takes the extra cycle
      slow_next = 1'b1;
      pend_next = 1'b0;
      redirect_next = 1'b0;
      stall_next = 1'b0;
    end
  end

  // Read mux; data appears the cycle after the strobe
  always @* begin
    rdata_next = 32'h00000000;
    if (reg_rd_in) begin
      case (reg_addr_in)
        `ZOL_OFF_COUNT: begin
          rdata_next = to_word(iteration_counter_reg);
        end
        `ZOL_OFF_BEGIN: begin
          rdata_next = to_word(loop_begin_address_reg);
        end
        `ZOL_OFF_END: begin
          rdata_next = to_word(loop_end_address_reg);
        end
        `ZOL_OFF_STATUS: begin
          rdata_next[`ZOL_ST_ACTIVE] = (iteration_counter_reg != {AW{1'b0}});
          rdata_next[`ZOL_ST_EXCM] = exception_mode_flag_in;
          rdata_next[`ZOL_ST_STALL] = slow_reg;
        end
        `ZOL_OFF_LOOPBACKS: begin
          rdata_next = loopbacks_reg;
        end
        default: begin
          rdata_next = 32'h00000000;
        end
      endcase
    end
  end

  // State registers
  always @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      iteration_counter_reg <= {AW{1'b0}};
      loop_begin_address_reg <= {AW{1'b0}};
      loop_end_address_reg <= {AW{1'b0}};
      slow_reg <= 1'b1;
      pend_reg <= 1'b0;
      loopbacks_reg <= `ZOL_RST_WORD;
    end else begin
      iteration_counter_reg <= iteration_counter_next;
      loop_begin_address_reg <= loop_begin_address_next;
      loop_end_address_reg <= loop_end_address_next;
      slow_reg <= slow_next;
      pend_reg <= pend_next;
      loopbacks_reg <= loopbacks_next;
    end
  end

  // Output flops; all outputs come straight from here
  always @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      reg_rdata_out <= `ZOL_RST_WORD;
      redirect_out <= 1'b0;
      redirect_pc_out <= {AW{1'b0}};
      fetch_stall_out <= 1'b0;
      iteration_counter_out <= {AW{1'b0}};
      loop_begin_address_out <= {AW{1'b0}};
      loop_end_address_out <= {AW{1'b0}};
    end else begin
      reg_rdata_out <= rdata_next;
      redirect_out <= redirect_next;
      redirect_pc_out <= redirect_pc_next;
      fetch_stall_out <= stall_next;
      iteration_counter_out <= iteration_counter_next;
      loop_begin_address_out <= loop_begin_address_next;
      loop_end_address_out <= loop_end_address_next;
    end
  end
endmodule

// *** hdl/zol_map.vh ***
// Constants for the zero-overhead loop controller
`ifndef ZOL_MAP_VH
`define ZOL_MAP_VH
// Register offsets on the plain register port
`define ZOL_OFF_COUNT 4'h0
`define ZOL_OFF_BEGIN 4'h1
`define ZOL_OFF_END 4'h2
`define ZOL_OFF_STATUS 4'h3
`define ZOL_OFF_LOOPBACKS 4'h4
// Status field positions
`define ZOL_ST_ACTIVE 0
`define ZOL_ST_EXCM 1
`define ZOL_ST_STALL 2
// Address arithmetic for loop setup
`define ZOL_BEGIN_INC 32'h00000003
`define ZOL_END_INC 32'h00000004
// Reset values
`define ZOL_RST_WORD 32'h00000000
// Extra cycles spent on a slowed loop-back
`define ZOL_SLOW_CYCLES 1
`endif

// *** hdl/zol_addr_cmp.v ***
// Loop-end comparator with sequential next-fetch address
`timescale 1ns/100ps
module zol_addr_cmp #(
  parameter AW = 32
) (
  // Fetch side
  input wire [AW-1:0] fetch_pc_in,
  input wire fetch_len3_in,
  // Loop end
  input wire [AW-1:0] loop_end_in,
  // Results
  output wire [AW-1:0] seq_pc_out,
  output wire hit_out
);
  // Length is 2 or 3 bytes; any alignment counts
  assign seq_pc_out = fetch_pc_in + (fetch_len3_in ? 32'h3 : 32'h2);
  assign hit_out = (seq_pc_out == loop_end_in);
endmodule

// *** test/zol_fetch_model.sv ***
// Fetch pipeline model that walks a loop body
`timescale 1ns/100ps
module zol_fetch_model (
  // Clock, reset and control
  input wire core_clk_in,
  input wire reset_in,
  input wire run_in,
  input wire jump_in,
  input wire len3_in,
  input wire [31:0] start_pc_in,
  // From the loop controller
  input wire redirect_in,
  input wire [31:0] redirect_pc_in,
  input wire stall_in,
  // Fetch side
  output reg fetch_valid_out,
  output reg fetch_seq_out,
  output reg [31:0] fetch_pc_out
);
  reg [31:0] pc_reg; // Next fetch address
  wire [31:0] nxt = redirect_in ? redirect_pc_in : pc_reg; // Follows redirects
  wire [31:0] step = len3_in ? 32'h3 : 32'h2; // Length of each fetched instruction
  always @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      pc_reg <= 32'h0;
      fetch_valid_out <= 1'h0;
      fetch_seq_out <= 1'h0;
      fetch_pc_out <= 32'h0;
    end else begin
      // Idle address toggles so stale values never match
      fetch_pc_out <= run_in ? nxt : ~fetch_pc_out;
      pc_reg <= run_in ? nxt + (stall_in ? 32'h0 : step) : start_pc_in;
      fetch_valid_out <= run_in & ~stall_in;
      fetch_seq_out <= ~jump_in;
    end
  end
endmodule

// *** test/zol_loop_monitor.sv ***
// Port assertions for the loop controller
`timescale 1ns/100ps
module zol_loop_monitor #(
  parameter AW = 32
) (
  // Clock and reset
  input wire core_clk_in,
  input wire reset_in,
  // Inputs watched
  input wire setup_valid_in,
  input wire [AW-1:0] setup_pc_in,
  input wire [AW-1:0] setup_src_in,
  input wire [7:0] loop_offset_field_in,
  input wire exception_mode_flag_in,
  input wire fetch_valid_in,
  input wire fetch_seq_in,
  input wire reg_rd_in,
  // Outputs watched
  input wire [31:0] reg_rdata_out,
  input wire redirect_out,
  input wire [AW-1:0] redirect_pc_out,
  input wire fetch_stall_out,
  input wire [AW-1:0] iteration_counter_out,
  input wire [AW-1:0] loop_begin_address_out,
  input wire [AW-1:0] loop_end_address_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  a_count_load: assert property (setup_valid_in |=>
    iteration_counter_out == $past(setup_src_in) - 1) else $error("bad count load");
  a_end_load: assert property (setup_valid_in |=> loop_end_address_out ==
    $past(setup_pc_in) + 32'h4 + {24'h0, $past(loop_offset_field_in)}) else $error("bad end");
  a_begin_load: assert property (setup_valid_in |=>
    loop_begin_address_out == $past(setup_pc_in) + 32'h3) else $error("bad begin");
  a_redir_pc: assert property (redirect_out |->
    redirect_pc_out == loop_begin_address_out) else $error("bad redirect target");
  a_redir_dec: assert property (redirect_out |->
    iteration_counter_out == $past(iteration_counter_out) - 1) else $error("no decrement");
  a_zero_stop: assert property (iteration_counter_out == 0 && !fetch_stall_out |=>
    !redirect_out) else $error("loop-back at zero count");
  a_seq_cause: assert property (redirect_out && !$past(fetch_stall_out) |->
    $past(fetch_valid_in && fetch_seq_in)) else $error("loop-back without fetch");
  a_excm_quiet: assert property ($past(exception_mode_flag_in) &&
    $past(exception_mode_flag_in, 2) && $past(exception_mode_flag_in, 3) |-> !redirect_out)
    else $error("loop-back in exception mode");
  a_stall_redir: assert property (fetch_stall_out |=> redirect_out)
    else $error("stall without redirect");
  a_rd_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
    else $error("read data outside slot");
endmodule
bind zol_loop_ctrl zol_loop_monitor #(.AW(AW)) u_mon (.*);

// *** test/zol_loop_ctrl_tb.sv ***
// Self-checking bench for the loop controller
`timescale 1ns/100ps
module zol_loop_ctrl_tb;
  reg core_clk_in = 1'h0;
  reg reset_in = 1'h1;
  reg setup_valid_in = 1'h0;
  reg [31:0] setup_pc_in = 32'h0;
  reg [31:0] setup_src_in = 32'h0;
  reg [7:0] loop_offset_field_in = 8'h0;
  reg exception_mode_flag_in = 1'h0;
  reg instruction_sync_op_in = 1'h0;
  reg fetch_len3_in = 1'h1; // Three-byte body except in t_short
  reg [3:0] reg_addr_in = 4'h0;
  reg [31:0] reg_wdata_in = 32'h0;
  reg reg_wr_in = 1'h0;
  reg reg_rd_in = 1'h0;
  reg run = 1'h0;
  reg jump = 1'h0;
  wire fetch_valid_in, fetch_seq_in, redirect_out, fetch_stall_out;
  wire [31:0] fetch_pc_in, reg_rdata_out, redirect_pc_out;
  wire [31:0] iteration_counter_out, loop_begin_address_out, loop_end_address_out;
  integer fails = 0;
  integer n_checks = 0;
  // Clock at 25 MHz
  always #20 core_clk_in = ~core_clk_in;
  zol_loop_ctrl u_dut (.*);
  zol_fetch_model u_fetch (.core_clk_in(core_clk_in), .reset_in(reset_in), .run_in(run),
    .jump_in(jump), .len3_in(fetch_len3_in), .start_pc_in(32'h103),
    .redirect_in(redirect_out),
    .redirect_pc_in(redirect_pc_out), .stall_in(fetch_stall_out),
    .fetch_valid_out(fetch_valid_in), .fetch_seq_out(fetch_seq_in), .fetch_pc_out(fetch_pc_in));
  task check(input [31:0] got, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // One setup at 0x100, three-instruction body, then fetch for 40 cycles
  task run_loop(input [31:0] src, input ex, input jp, input sy, input [31:0] nr, ns);
    integer i, r, s;
    begin
      r = 0;
      s = 0;
      @(posedge core_clk_in);
      {exception_mode_flag_in, jump, setup_valid_in} <= {ex, jp, 1'h1};
      {setup_pc_in, setup_src_in, loop_offset_field_in} <= {32'h100, src, 8'h08};
      @(posedge core_clk_in);
      setup_valid_in <= 1'h0;
      run <= 1'h1;
      #1 check(iteration_counter_out, src - 32'h1);
      check(loop_end_address_out, 32'h10c);
      for (i = 0; i < 40; i = i + 1) begin
        @(posedge core_clk_in);
        instruction_sync_op_in <= sy && i == 8;
        #1 r = r + redirect_out;
        s = s + fetch_stall_out;
      end
      run <= 1'h0;
      check(r, nr);
      check(s, ns);
      check(iteration_counter_out, src - 32'h1 - nr);
    end
  endtask
  // Two-byte body: the compare sees every sequential address
  task t_short;
    integer i, r;
    begin
      r = 0;
      @(posedge core_clk_in);
      {setup_valid_in, setup_pc_in, setup_src_in} <= {1'h1, 32'h100, 32'h2};
      {loop_offset_field_in, fetch_len3_in, jump} <= {8'h07, 1'h0, 1'h0};
      @(posedge core_clk_in);
      setup_valid_in <= 1'h0;
      run <= 1'h1;
      for (i = 0; i < 30; i = i + 1) begin
        @(posedge core_clk_in);
        #1 r = r + redirect_out;
      end
      run <= 1'h0;
      fetch_len3_in <= 1'h1;
      check(r, 32'h1);
      check(iteration_counter_out, 32'h0);
    end
  endtask
  // Zero count wraps, widest offset, overwrites the old loop
  task t_wrap;
    begin
      @(posedge core_clk_in);
      {setup_valid_in, setup_pc_in, setup_src_in} <= {1'h1, 32'h200, 32'h0};
      loop_offset_field_in <= 8'hff;
      @(posedge core_clk_in);
      setup_valid_in <= 1'h0;
      #1 check(iteration_counter_out, 32'hffffffff);
      check(loop_end_address_out, 32'h303);
      check(loop_begin_address_out, 32'h203);
    end
  endtask
  task reg_io(input wr, input [3:0] a, input [31:0] d);
    begin
      @(posedge core_clk_in);
      {reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in} <= {wr, ~wr, a, d};
      @(posedge core_clk_in);
      {reg_wr_in, reg_rd_in} <= 2'h0;
      #1 if (!wr) check(reg_rdata_out, d);
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  initial begin
    repeat (5) @(posedge core_clk_in);
    reset_in <= 1'h0;
    #1 check(iteration_counter_out, 32'h0);
    run_loop(32'h3, 1'h0, 1'h0, 1'h0, 32'h2, 32'h1);
    run_loop(32'h4, 1'h0, 1'h0, 1'h1, 32'h3, 32'h2);
    run_loop(32'h3, 1'h1, 1'h0, 1'h0, 32'h0, 32'h0);
    run_loop(32'h3, 1'h0, 1'h1, 1'h0, 32'h0, 32'h0);
    t_short;
    t_wrap;
    reg_io(1'h0, 4'h0, 32'hffffffff);
    reg_io(1'h0, 4'h3, 32'h5);
    reg_io(1'h1, 4'h4, 32'h7);
    reg_io(1'h0, 4'h4, 32'h7);
    reg_io(1'h0, 4'hf, 32'h0);
    give_verdict;
  end
endmodule
